/* File: testbench/stm_chk_assertions.sv */
`timescale 1ns/1ps
module stm_chk
  import stm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        lkp_req,
  input wire logic [47:0] lkp_da,
  input wire logic        lkp_done,
  input wire logic        lkp_vlan_valid,
  input wire logic [6:0]  lkp_filter_id,
  input wire logic [6:0]  lkp_member_mask,
  input wire logic [11:0] lkp_alu_index,
  input wire logic [6:0]  lkp_static_mask,
  input wire logic        vlan_mode_en
);
  logic acc;
  logic map;

  // Access phase and decode of the implemented offsets
  assign acc = psel && penable;
  assign map = paddr inside {VLAN_E0_OFS, VLAN_E1_OFS, VLAN_E2_OFS,
    VLAN_IDX_OFS, VLAN_CTL_OFS, MODE_OFS, TBL_CTL_OFS, WORD2_OFS,
    WORD3_OFS, WORD4_OFS};

  // Own copy of the fold, so a slip in the design's copy shows
  function automatic logic [11:0] fold(logic [54:0] v);
    logic [59:0] x;
    x = {5'h00, v};
    fold = x[11:0] ^ x[23:12] ^ x[35:24] ^ x[47:36] ^ x[59:48];
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_acc: assert property (acc |-> pready)
    else $error("pready missing in access phase");
  a_ready_setup: assert property (psel && !penable |-> !pready)
    else $error("pready high in setup cycle");
  a_unmapped_err: assert property (acc && !map |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && map |-> !pslverr)
    else $error("error on mapped access");
  a_lookup_lat: assert property (lkp_req |-> ##2 lkp_done)
    else $error("lookup not answered in two cycles");
  a_done_cause: assert property (lkp_done |-> $past(lkp_req, 2))
    else $error("lookup done without request");
  a_mode_off: assert property (lkp_done && !$past(vlan_mode_en)
    |-> !lkp_vlan_valid && lkp_filter_id == 7'h00)
    else $error("vlan result while mode off");
  a_result_hold: assert property (!lkp_done |->
    $stable(lkp_member_mask) && $stable(lkp_static_mask))
    else $error("lookup result moved without done");
  a_alu_hash: assert property (lkp_done |->
    lkp_alu_index == fold({lkp_filter_id, $past(lkp_da, 2)}))
    else $error("address table index wrong");
  a_mode_write: assert property (acc && pwrite && paddr == MODE_OFS
    |=> vlan_mode_en == $past(pwdata[0]))
    else $error("mode bit not written");
endmodule

bind stm_top stm_chk i_stm_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lkp_req(lkp_req), .lkp_da(lkp_da), .lkp_done(lkp_done),
  .lkp_vlan_valid(lkp_vlan_valid), .lkp_filter_id(lkp_filter_id),
  .lkp_member_mask(lkp_member_mask), .lkp_alu_index(lkp_alu_index),
  .lkp_static_mask(lkp_static_mask), .vlan_mode_en(vlan_mode_en));

/* File: testbench/stm_top_bench.sv */
`timescale 1ns/1ps
module stm_top_bench;
  import stm_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lkp_req = 1'b0;
  logic [11:0] lkp_vid = 12'h000;
  logic [47:0] lkp_da = 48'h0;
  logic        lkp_mcast = 1'b0;
  logic        lkp_done;
  logic        lkp_vlan_valid;
  logic        lkp_member_fwd_sel;
  logic [2:0]  lkp_priority;
  logic [2:0]  lkp_spanning_group;
  logic [6:0]  lkp_filter_id;
  logic [6:0]  lkp_untag_mask;
  logic [6:0]  lkp_member_mask;
  logic [11:0] lkp_alu_index;
  logic        lkp_static_hit;
  logic [6:0]  lkp_static_mask;
  logic        lkp_static_override;
  logic        vlan_mode_en;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          seed = 32'h003e;
  logic [31:0] r;
  logic        e;
  logic [31:0] d;
  logic [31:0] wm [3] = '{32'hc000_007f, 32'h007f_ffff, 32'hffff_ffff};
  logic [6:0]  gm [8];
  logic [31:0] w2m [16];
  logic [6:0]  filter_id [16];
  logic [47:0] mac [16];
  logic [31:0] ve [4][3];
  logic [11:0] vid [4];

  stm_top i_stm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lkp_req(lkp_req), .lkp_vid(lkp_vid), .lkp_da(lkp_da),
    .lkp_mcast(lkp_mcast), .lkp_done(lkp_done),
    .lkp_vlan_valid(lkp_vlan_valid),
    .lkp_member_fwd_sel(lkp_member_fwd_sel),
    .lkp_priority(lkp_priority), .lkp_spanning_group(lkp_spanning_group),
    .lkp_filter_id(lkp_filter_id), .lkp_untag_mask(lkp_untag_mask),
    .lkp_member_mask(lkp_member_mask), .lkp_alu_index(lkp_alu_index),
    .lkp_static_hit(lkp_static_hit), .lkp_static_mask(lkp_static_mask),
    .lkp_static_override(lkp_static_override),
    .vlan_mode_en(vlan_mode_en));

  // 125 MHz
  always #4 pclk = ~pclk;

  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One transfer; waits on pready, the watchdog ends a stalled wait
  task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start a table operation and poll its start bit until it drops
  task automatic op(logic [11:0] a, logic [31:0] v);
    int k;
    k = 0;
    apb(1'b1, a, v);
    r = 32'h0000_0080;
    while (r[GO_BIT] !== 1'b0 && k < 8)
    begin
      apb(1'b0, a, 32'h0);
      k++;
    end
    chk(r[GO_BIT], 1'b0);
  endtask

  // Lookup pulse; results stand from the edge after the sampling edge
  task automatic look(logic [11:0] v, logic [47:0] da, logic mc);
    @(posedge pclk);
    lkp_req <= 1'b1;
    lkp_vid <= v;
    lkp_da <= da;
    lkp_mcast <= mc;
    @(posedge pclk);
    lkp_req <= 1'b0;
    @(posedge pclk);
    #1;
    chk(lkp_done, 1'b1);
  endtask

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Data words: reset value, then only writable bits stick
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, WORD2_OFS + 12'(4 * i), 32'h0);
      chk(r, REG_RST);
      d = $random(seed);
      apb(1'b1, WORD2_OFS + 12'(4 * i), d);
      apb(1'b0, WORD2_OFS + 12'(4 * i), 32'h0);
      chk(r, d & wm[i]);
    end
    apb(1'b0, 12'h430, 32'h0);
    chk({e, r}, 33'h1_0000_0000);
    $display("test registers done");
    // One write per group, landing on a fixed member of it, index g + 8 * ((g * 5 + 1) % 6)
    for (int g = 0; g < 8; g++)
    begin
      gm[g] = 7'($random(seed));
      d = $random(seed);
      d[6:0] = gm[g];
      apb(1'b1, WORD2_OFS, d);
      op(TBL_CTL_OFS,
        {26'h000_0003, 6'(g + 8 * ((g * 5 + 1) % 6))});
    end
    // Index past the table must not disturb group 0
    apb(1'b1, WORD2_OFS, 32'h7f);
    op(TBL_CTL_OFS, 32'h0000_00f8);
    for (int i = 0; i < 50; i++)
    begin
      op(TBL_CTL_OFS, {26'h000_0007, 6'(i)});
      apb(1'b0, WORD2_OFS, 32'h0);
      chk(r, i < 48 ? 32'(gm[i % 8]) : 32'h0);
    end
    $display("test reserved multicast done");
    // Fill every static entry so no lookup meets an unwritten one
    for (int i = 0; i < 16; i++)
    begin
      w2m[i] = ($random(seed) & 32'h8000_007f) | 32'h4000_0000;
      filter_id[i] = 7'($random(seed)) | 7'h01;
      mac[i] = {i[7:0], 32'($random(seed)), 8'h00};
      apb(1'b1, WORD2_OFS, w2m[i]);
      apb(1'b1, WORD3_OFS, {9'h0, filter_id[i], mac[i][47:32]});
      apb(1'b1, WORD4_OFS, mac[i][31:0]);
      op(TBL_CTL_OFS, 32'(i) | 32'h0000_0080);
    end
    op(TBL_CTL_OFS, 32'h0000_0189);
    apb(1'b0, WORD2_OFS, 32'h0);
    chk(r, w2m[9]);
    apb(1'b0, WORD3_OFS, 32'h0);
    chk(r, {9'h0, filter_id[9], mac[9][47:32]});
    apb(1'b0, WORD4_OFS, 32'h0);
    chk(r, mac[9][31:0]);
    // VLAN entry 0 gets the reset data words, so lookups see known data
    op(VLAN_CTL_OFS, 32'h0000_0080);
    look(12'h000, mac[9], 1'b0);
    chk({lkp_static_hit, lkp_static_override, lkp_static_mask},
      {1'b1, w2m[9][31], w2m[9][6:0]});
    // Filter id is 0 with mode off, so a multicast must miss
    look(12'h000, mac[9], 1'b1);
    chk(lkp_static_hit, 1'b0);
    look(12'h000, 48'hffff_ffff_ffff, 1'b0);
    chk(lkp_static_hit, 1'b0);
    $display("test static table done");
    // Table filled before mode is enabled, both end indices used
    for (int v = 0; v < 4; v++)
    begin
      vid[v] = v == 0 ? 12'h000 : v == 1 ? 12'hfff
        : {4'(v), 8'($random(seed))};
      for (int w = 0; w < 3; w++)
      begin
        ve[v][w] = $random(seed);
        apb(1'b1, VLAN_E0_OFS + 12'(4 * w), ve[v][w]);
      end
      apb(1'b1, VLAN_IDX_OFS, 32'(vid[v]));
      op(VLAN_CTL_OFS, 32'h0000_0080);
    end
    for (int v = 3; v >= 0; v--)
    begin
      apb(1'b1, VLAN_IDX_OFS, 32'(vid[v]));
      op(VLAN_CTL_OFS, 32'h0000_0081);
      for (int w = 0; w < 3; w++)
      begin
        apb(1'b0, VLAN_E0_OFS + 12'(4 * w), 32'h0);
        chk(r, ve[v][w] & (w == 0 ? 32'h8f07_007f : 32'h7f));
      end
    end
    // Mode still off: valid, select and filter_id come out as zero
    look(vid[0], 48'h0, 1'b0);
    chk({lkp_vlan_valid, lkp_member_fwd_sel, lkp_priority,
      lkp_spanning_group, lkp_filter_id},
      {2'b00, ve[0][0][26:24], ve[0][0][18:16], 7'h00});
    apb(1'b1, MODE_OFS, 32'h1);
    #1;
    chk(vlan_mode_en, 1'b1);
    for (int v = 0; v < 4; v++)
    begin
      d = $random(seed);
      look(vid[v], {d, d[15:0]}, 1'b0);
      chk({lkp_vlan_valid, lkp_member_fwd_sel, lkp_priority,
        lkp_spanning_group, lkp_filter_id, lkp_untag_mask,
        lkp_member_mask}, {ve[v][0][31], ve[v][0][27], ve[v][0][26:24],
        ve[v][0][18:16], ve[v][0][6:0], ve[v][1][6:0],
        ve[v][2][6:0]});
    end
    $display("test vlan table done");
    give_verdict;
  end

  // Whole run is about 1250 cycles; this is ample margin
  initial
  begin
    #200000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule

/* File: verilog/stm_pkg.sv */
package stm_pkg;
  // Register byte offsets
  localparam logic [11:0] VLAN_E0_OFS   = 12'h400;
  localparam logic [11:0] VLAN_E1_OFS   = 12'h404;
  localparam logic [11:0] VLAN_E2_OFS   = 12'h408;
  localparam logic [11:0] VLAN_IDX_OFS  = 12'h40c;
  localparam logic [11:0] VLAN_CTL_OFS  = 12'h410;
  localparam logic [11:0] MODE_OFS      = 12'h414;
  localparam logic [11:0] TBL_CTL_OFS   = 12'h41c;
  localparam logic [11:0] WORD2_OFS     = 12'h424;
  localparam logic [11:0] WORD3_OFS     = 12'h428;
  localparam logic [11:0] WORD4_OFS     = 12'h42c;
  // Reset value shared by every register
  localparam logic [31:0] REG_RST       = 32'h0000_0000;
  // Shared table control fields
  localparam int SEL_LSB   = 0;
  localparam int SEL_W     = 6;
  localparam int TSEL_BIT  = 6;
  localparam int GO_BIT    = 7;
  localparam int RW_BIT    = 8;
  // VLAN access control fields
  localparam int VRW_BIT   = 0;
  // Second word fields
  localparam int OVR_BIT   = 31;
  localparam int UFID_BIT  = 30;
  localparam int MASK_LSB  = 0;
  // Third word fields
  localparam int FID_LSB   = 16;
  localparam int MACH_LSB  = 0;
  // VLAN entry word 0 fields
  localparam int V_VALID   = 31;
  localparam int V_FWDSEL  = 27;
  localparam int V_PRIO    = 24;
  localparam int V_SPAN    = 16;
  localparam int V_FID     = 0;
  // Table geometry
  localparam int NPORT     = 7;
  localparam int FIDW      = 7;
  localparam int RSVD_NUM  = 48;
  localparam int RSVD_GRPS = 8;
  localparam int VLAN_AW   = 12;
  localparam int VLAN_DW   = 29;
  localparam int ST_AW     = 4;
  localparam int ST_DW     = 64;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SOP  = 3'b010,
    ST_VOP  = 3'b100
  } stm_state_t;
endpackage

/* File: verilog/stm_static_tbl.sv */
`timescale 1ns/1ps
// Static entries: host port plus combinational destination match
module stm_static_tbl #(
  parameter int N = 16
) (
  input  wire logic        pclk,
  stm_tbl_if.mem           hp,
  input  wire logic [47:0] da,
  input  wire logic        mcast,
  input  wire logic [6:0]  filter_id,
  output logic             hit,
  output logic      [6:0]  mask,
  output logic             ovr
);
  // Entry packing: {ovr, multicast_filter_match, mask[6:0], fid[6:0], mac[47:0]}
  logic [63:0] ent [N];

  always_ff @(posedge pclk)
  begin
    if (hp.wr)
      ent[hp.idx] <= hp.wdata;
    if (hp.rd)
      hp.rdata <= ent[hp.idx];
  end

  // Lowest matching entry wins
  always_comb
  begin
    hit  = 1'b0;
    mask = '0;
    ovr  = 1'b0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (ent[i][47:0] == da &&
          !(mcast && ent[i][62] && ent[i][54:48] != filter_id))
      begin
        hit  = 1'b1;
        mask = ent[i][61:55];
        ovr  = ent[i][63];
      end
    end
  end
endmodule

/* File: verilog/stm_tbl_if.sv */
`timescale 1ns/1ps
// Host-side access port of one table memory
interface stm_tbl_if #(
  parameter int AW = 4,
  parameter int DW = 64
);
  logic          wr;
  logic          rd;
  logic [AW-1:0] idx;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport host (output wr, rd, idx, wdata, input rdata);
  modport mem  (input wr, rd, idx, wdata, output rdata);
endinterface

/* File: verilog/stm_top.sv */
// Overview of operation
// - Word2 bit31 enables port state override
// - Word2 bit30 adds filter_id to multicast match
// - Bits 6:0 per-port forward mask
// - Word3 filter_id and MAC high, word4 low
// - Reserved multicast table, 48 addresses, 6-bit index
// - Mask write updates whole fixed group
// - table_choice 1 selects reserved multicast table
// - Device clears go_done when access finishes
// - VLAN mode looks up 4096-entry table
// - VLAN entry holds valid, select, priority, group, id
// - member_forward_sel picks membership mask forwarding
// - filter_id hashed with address gives index
// - Per-port egress untag mask
// - Per-port membership mask, bit0 port 1
// - Host index equals lookup VLAN identifier
// - Device clears VLAN start bit on completion
`timescale 1ns/1ps
module stm_top
  import stm_pkg::*;
#(
  parameter int VLAN_DEPTH = 4096,
  parameter int ST_ENTRIES = 16
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  lkp_req,
  input  wire logic [stm_pkg::VLAN_AW-1:0] lkp_vid,
  input  wire logic [47:0]           lkp_da,
  input  wire logic                  lkp_mcast,
  output logic                       lkp_done,
  output logic                       lkp_vlan_valid,
  output logic                       lkp_member_fwd_sel,
  output logic      [2:0]            lkp_priority,
  output logic      [2:0]            lkp_spanning_group,
  output logic      [6:0]            lkp_filter_id,
  output logic      [6:0]            lkp_untag_mask,
  output logic      [6:0]            lkp_member_mask,
  output logic      [11:0]           lkp_alu_index,
  output logic                       lkp_static_hit,
  output logic      [6:0]            lkp_static_mask,
  output logic                       lkp_static_override,
  output logic                       vlan_mode_en
);
  import stm_pkg::*;

  // Address match for one register word
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a[11:2] == o[11:2];
  endfunction

  // Fixed grouping of the reserved addresses by low index bits
  function automatic logic [2:0] grp(input logic [5:0] i);
    return i[2:0];
  endfunction

  // Fold filter_id and address down to an address table index
  function automatic logic [11:0] hash(input logic [6:0] f,
                                       input logic [47:0] d);
    logic [59:0] k;
    k = {5'h00, f, d};
    return k[11:0] ^ k[23:12] ^ k[35:24] ^ k[47:36] ^ k[59:48];
  endfunction

  stm_tbl_if #(.AW(ST_AW),   .DW(ST_DW))   st_if ();
  stm_tbl_if #(.AW(VLAN_AW), .DW(VLAN_DW)) vl_if ();

  stm_state_t     state_q;
  logic [31:0]    w2_q;
  logic [22:0]    w3_q;
  logic [31:0]    w4_q;
  logic [31:0]    ve0_q;
  logic [6:0]     ve1_q;
  logic [6:0]     ve2_q;
  logic [11:0]    vidx_q;
  logic           vrw_q;
  logic           vgo_q;
  logic [5:0]     sel_q;
  logic           tsel_q;
  logic           rw_q;
  logic           go_q;
  logic [6:0]     rsvd_q [RSVD_GRPS];
  logic           setup;
  logic           acc_wr;
  logic           mapped;
  logic [31:0]    rd_d;
  logic           issue_s;
  logic           issue_v;
  logic           lk_q;
  logic [47:0]    da_q;
  logic           mc_q;
  logic [28:0]    lk_data;
  logic [6:0]     lk_fid;
  logic           s_hit;
  logic [6:0]     s_mask;
  logic           s_ovr;
  logic [VLAN_DW-1:0] v_pack;

  // Bus phases; reads are prepared in the setup cycle
  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pready & pwrite;

  // Zero wait state: ready rises in every access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  // Decoder of the mapped words
  always_comb
  begin
    mapped = hit(paddr, VLAN_E0_OFS) | hit(paddr, VLAN_E1_OFS) |
             hit(paddr, VLAN_E2_OFS) | hit(paddr, VLAN_IDX_OFS) |
             hit(paddr, VLAN_CTL_OFS) | hit(paddr, MODE_OFS) |
             hit(paddr, TBL_CTL_OFS) | hit(paddr, WORD2_OFS) |
             hit(paddr, WORD3_OFS) | hit(paddr, WORD4_OFS);
  end

  // Read mux; reserved bits read zero
  always_comb
  begin
    rd_d = '0;
    if (hit(paddr, VLAN_E0_OFS))
      rd_d = ve0_q;
    else if (hit(paddr, VLAN_E1_OFS))
      rd_d = {25'h0, ve1_q};
    else if (hit(paddr, VLAN_E2_OFS))
      rd_d = {25'h0, ve2_q};
    else if (hit(paddr, VLAN_IDX_OFS))
      rd_d = {20'h0, vidx_q};
    else if (hit(paddr, VLAN_CTL_OFS))
    begin
      rd_d[GO_BIT]  = vgo_q;
      rd_d[VRW_BIT] = vrw_q;
    end
    else if (hit(paddr, MODE_OFS))
      rd_d[0] = vlan_mode_en;
    else if (hit(paddr, TBL_CTL_OFS))
    begin
      rd_d[SEL_LSB +: SEL_W] = sel_q;
      rd_d[TSEL_BIT] = tsel_q;
      rd_d[GO_BIT]   = go_q;
      rd_d[RW_BIT]   = rw_q;
    end
    else if (hit(paddr, WORD2_OFS))
      rd_d = w2_q;
    else if (hit(paddr, WORD3_OFS))
      rd_d = {9'h000, w3_q};
    else if (hit(paddr, WORD4_OFS))
      rd_d = w4_q;
  end

  // Read data and error answer, held through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= REG_RST;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? REG_RST : rd_d;
      pslverr <= ~mapped;
    end
  end

  // Operation launch, one table per cycle, static side first
  assign issue_s = (state_q == ST_IDLE) & go_q;
  assign issue_v = (state_q == ST_IDLE) & ~go_q & vgo_q;

  // Sequencer: one cycle of access, then completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (issue_s)
            state_q <= ST_SOP;
          else if (issue_v)
            state_q <= ST_VOP;
        end
        ST_SOP:  state_q <= ST_IDLE;
        ST_VOP:  state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Static table port; low 4 select bits address it
  assign st_if.wr    = issue_s & ~tsel_q & ~rw_q;
  assign st_if.rd    = issue_s & ~tsel_q & rw_q;
  assign st_if.idx   = sel_q[ST_AW-1:0];
  assign st_if.wdata = {w2_q[OVR_BIT], w2_q[UFID_BIT],
                        w2_q[MASK_LSB +: NPORT],
                        w3_q[FID_LSB +: FIDW], w3_q[15:0], w4_q};

  // Fixed VLAN packing used for both directions
  assign v_pack = {ve0_q[V_VALID], ve0_q[V_FWDSEL],
                   ve0_q[V_PRIO +: 3], ve0_q[V_SPAN +: 3],
                   ve0_q[V_FID +: FIDW], ve1_q, ve2_q};
  assign vl_if.wr    = issue_v & ~vrw_q;
  assign vl_if.rd    = issue_v & vrw_q;
  assign vl_if.idx   = vidx_q;
  assign vl_if.wdata = v_pack;

  // Shared control: software sets go, hardware clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q  <= '0;
      tsel_q <= 1'b0;
      rw_q   <= 1'b0;
      go_q   <= 1'b0;
    end
    else if (state_q == ST_SOP)
      go_q <= 1'b0;
    else if (acc_wr && hit(paddr, TBL_CTL_OFS) && !go_q)
    begin
      // Busy writes are dropped so a running access stays intact
      sel_q  <= pwdata[SEL_LSB +: SEL_W];
      tsel_q <= pwdata[TSEL_BIT];
      rw_q   <= pwdata[RW_BIT];
      go_q   <= pwdata[GO_BIT];
    end
  end

  // VLAN access control and index
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vrw_q  <= 1'b0;
      vgo_q  <= 1'b0;
      vidx_q <= '0;
    end
    else if (state_q == ST_VOP)
      vgo_q <= 1'b0;
    else if (!vgo_q)
    begin
      if (acc_wr && hit(paddr, VLAN_CTL_OFS))
      begin
        vrw_q <= pwdata[VRW_BIT];
        vgo_q <= pwdata[GO_BIT];
      end
      if (acc_wr && hit(paddr, VLAN_IDX_OFS))
        vidx_q <= pwdata[VLAN_AW-1:0];
    end
  end

  // Lookup enable; table must be loaded first by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vlan_mode_en <= 1'b0;
    else if (acc_wr && hit(paddr, MODE_OFS))
      vlan_mode_en <= pwdata[0];
  end

  // Reserved multicast masks, one per group
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int g = 0; g < RSVD_GRPS; g++)
        rsvd_q[g] <= '0;
    else if (issue_s && tsel_q && !rw_q && sel_q < RSVD_NUM)
      rsvd_q[grp(sel_q)] <= w2_q[MASK_LSB +: NPORT];
  end

  // Shared data words; a completing read overrides a host write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      w2_q <= REG_RST;
      w3_q <= '0;
      w4_q <= REG_RST;
    end
    else if (state_q == ST_SOP && rw_q && tsel_q)
    begin
      w2_q <= '0;
      if (sel_q < RSVD_NUM)
        w2_q[MASK_LSB +: NPORT] <= rsvd_q[grp(sel_q)];
    end
    else if (state_q == ST_SOP && rw_q)
    begin
      w2_q <= {st_if.rdata[63:62], 23'h0, st_if.rdata[61:55]};
      w3_q <= {st_if.rdata[54:48], st_if.rdata[47:32]};
      w4_q <= st_if.rdata[31:0];
    end
    else if (acc_wr)
    begin
      if (hit(paddr, WORD2_OFS))
        w2_q <= {pwdata[31:30], 23'h0, pwdata[6:0]};
      if (hit(paddr, WORD3_OFS))
        w3_q <= pwdata[22:0];
      if (hit(paddr, WORD4_OFS))
        w4_q <= pwdata;
    end
  end

  // VLAN data words; read results unpacked with the same layout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ve0_q <= REG_RST;
      ve1_q <= '0;
      ve2_q <= '0;
    end
    else if (state_q == ST_VOP && vrw_q)
    begin
      ve0_q           <= REG_RST;
      ve0_q[V_VALID]  <= vl_if.rdata[28];
      ve0_q[V_FWDSEL] <= vl_if.rdata[27];
      ve0_q[V_PRIO +: 3] <= vl_if.rdata[26:24];
      ve0_q[V_SPAN +: 3] <= vl_if.rdata[23:21];
      ve0_q[V_FID +: FIDW] <= vl_if.rdata[20:14];
      ve1_q <= vl_if.rdata[13:7];
      ve2_q <= vl_if.rdata[6:0];
    end
    else if (acc_wr)
    begin
      if (hit(paddr, VLAN_E0_OFS))
        ve0_q <= pwdata & 32'h8f07_007f;
      if (hit(paddr, VLAN_E1_OFS))
        ve1_q <= pwdata[6:0];
      if (hit(paddr, VLAN_E2_OFS))
        ve2_q <= pwdata[6:0];
    end
  end

  stm_static_tbl #(
    .N (ST_ENTRIES)
  ) u_static (
    .pclk  (pclk),
    .hp    (st_if.mem),
    .da    (da_q),
    .mcast (mc_q),
    .filter_id   (lk_fid),
    .hit   (s_hit),
    .mask  (s_mask),
    .ovr   (s_ovr)
  );

  stm_vlan_ram #(
    .DEPTH (VLAN_DEPTH),
    .AW    (VLAN_AW),
    .DW    (VLAN_DW)
  ) u_vlan (
    .pclk    (pclk),
    .hp      (vl_if.mem),
    .lk_rd   (lkp_req),
    .lk_addr (lkp_vid),
    .lk_data (lk_data)
  );

  // Without VLAN mode the lookup runs with filter_id zero
  assign lk_fid = vlan_mode_en ? lk_data[20:14] : 7'h00;

  // Lookup stage 1: hold the frame fields while the RAM reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_q <= 1'b0;
      da_q <= '0;
      mc_q <= 1'b0;
    end
    else
    begin
      lk_q <= lkp_req;
      if (lkp_req)
      begin
        da_q <= lkp_da;
        mc_q <= lkp_mcast;
      end
    end
  end

  // Lookup stage 2: registered results, one-cycle done pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lkp_done            <= 1'b0;
      lkp_vlan_valid      <= 1'b0;
      lkp_member_fwd_sel  <= 1'b0;
      lkp_priority        <= '0;
      lkp_spanning_group  <= '0;
      lkp_filter_id       <= '0;
      lkp_untag_mask      <= '0;
      lkp_member_mask     <= '0;
      lkp_alu_index       <= '0;
      lkp_static_hit      <= 1'b0;
      lkp_static_mask     <= '0;
      lkp_static_override <= 1'b0;
    end
    else
    begin
      lkp_done <= lk_q;
      if (lk_q)
      begin
        lkp_vlan_valid     <= vlan_mode_en & lk_data[28];
        lkp_member_fwd_sel <= vlan_mode_en & lk_data[27];
        lkp_priority       <= lk_data[26:24];
        lkp_spanning_group <= lk_data[23:21];
        lkp_filter_id      <= lk_fid;
        lkp_untag_mask     <= lk_data[13:7];
        lkp_member_mask    <= lk_data[6:0];
        lkp_alu_index      <= hash(lk_fid, da_q);
        lkp_static_hit     <= s_hit;
        lkp_static_mask    <= s_mask;
        lkp_static_override <= s_ovr;
      end
    end
  end
endmodule

/* File: verilog/stm_vlan_ram.sv */
`timescale 1ns/1ps
// VLAN entry store, one host port and one lookup read port
module stm_vlan_ram #(
  parameter int DEPTH = 4096,
  parameter int AW    = 12,
  parameter int DW    = 29
) (
  input  wire logic          pclk,
  stm_tbl_if.mem             hp,
  input  wire logic          lk_rd,
  input  wire logic [AW-1:0] lk_addr,
  output logic      [DW-1:0] lk_data
);
  logic [DW-1:0] mem [DEPTH];

  // Host write and read, one-cycle read latency
  always_ff @(posedge pclk)
  begin
    if (hp.wr)
      mem[hp.idx] <= hp.wdata;
    if (hp.rd)
      hp.rdata <= mem[hp.idx];
  end

  // Lookup read by VID, same latency as the host side
  always_ff @(posedge pclk)
  begin
    if (lk_rd)
      lk_data <= mem[lk_addr];
  end
endmodule
